// file: core/clock_source_control_defs.vh
/*
 * Offsets, field positions, reset values and timing counts of the
 * system clock source control.
 * Assumes inclusion by bare name from the core design files.
 */
`ifndef CLOCK_SOURCE_CONTROL_DEFS_VH
`define CLOCK_SOURCE_CONTROL_DEFS_VH

`define EXT_OSC_CTRL_ADDR 8'hB1
`define INT_OSC_CTRL_ADDR 8'hB2

`define INT_OSC_CTRL_RESET 8'h04
`define EXT_OSC_CTRL_RESET 8'h30

`define INT_LOSS_DET_BIT 7
`define INT_READY_BIT 4
`define INT_SRC_SEL_BIT 3
`define INT_OSC_EN_BIT 2
`define INT_FREQ_HI 1
`define INT_FREQ_LO 0

`define EXT_VALID_BIT 7
`define EXT_MODE_HI 6
`define EXT_MODE_LO 4
`define EXT_RSVD_BIT 3
`define EXT_FREQ_HI 2
`define EXT_FREQ_LO 0

`define MODE_CMOS 3'h2
`define MODE_CMOS_DIV2 3'h3
`define MODE_XTAL 3'h6
`define MODE_XTAL_DIV2 3'h7

// ready settle in system clocks after enable or frequency change
`define INT_SETTLE_CYCLES 8'h40
// missing-clock window in system clocks of the monitor
`define LOSS_TIMEOUT_CYCLES 8'h64
// crystal stable count in external clocks
`define XTAL_STABLE_EDGES 8'hFF

`endif

// file: core/clock_glitch_free_mux.v
/*
 * Glitch-free two-input clock switch.
 * Assumes both clock inputs toggle while a switch is in progress.
 */
`timescale 1ns/1ps
module clock_glitch_free_mux (
    input wire i_clk_a,
    input wire i_clk_b,
    input wire i_rstn,
    input wire i_sel_b,
    output wire o_clk
);
    reg a_s1_q, a_en_q, b_s1_q, b_en_q;

    // each side enables only after the other has stopped, on its falling edge
    always @(negedge i_clk_a or negedge i_rstn) begin
        if (!i_rstn) begin
            a_s1_q <= 1'b1;
            a_en_q <= 1'b1;
        end else begin
            a_s1_q <= ~i_sel_b & ~b_en_q;
            a_en_q <= a_s1_q;
        end
    end

    always @(negedge i_clk_b or negedge i_rstn) begin
        if (!i_rstn) begin
            b_s1_q <= 1'b0;
            b_en_q <= 1'b0;
        end else begin
            b_s1_q <= i_sel_b & ~a_en_q;
            b_en_q <= b_s1_q;
        end
    end

    assign o_clk = (i_clk_a & a_en_q) | (i_clk_b & b_en_q);
endmodule // clock_glitch_free_mux

// file: core/system_clock_source_control.v
/*
 * System clock source control: internal and external oscillator control
 * registers, external mode decoding and divide-by-two stage, crystal valid detection,
 * glitch-free source switch and missing-clock reset request.
 * Assumes the core drives an 8-bit special register port on i_clk and the
 * analog oscillators report their clocks and lock on plain inputs.
 */
// What this block does
// - detector enabled forces reset on missing external clock while it is selected
// - bits six and five read zero
// - ready flag set only when settled
// - select bit picks internal or external clock
// - enable bit powers internal oscillator
// - frequency field picks 2/4/8/16 MHz
// - crystal valid flag read-only, stable crystal
// - modes 00x off, 010/011 CMOS clock
// - 10x RC div2, 110/111 crystal
// - reserved bit three ignores writes
// - reset returns to internal oscillator
// - reset pin low disables both oscillators
`timescale 1ns/1ps
`include "clock_source_control_defs.vh"
module system_clock_source_control (
    input wire i_clk,
    input wire i_rstn,
    input wire i_reset_pin_n,
    input wire [7:0] i_reg_addr,
    input wire [7:0] i_reg_wdata,
    input wire i_reg_wr,
    input wire [7:0] i_reg_rd_addr,
    input wire i_int_osc_clk,
    input wire i_int_osc_locked,
    input wire i_ext_osc_clk,
    input wire i_pin_one_level,
    output reg [7:0] o_reg_rdata,
    output reg o_int_osc_enable,
    output reg [1:0] o_int_freq_sel,
    output reg o_ext_osc_enable,
    output reg [2:0] o_ext_freq_sel,
    output reg o_rc_mode,
    output reg o_xtal_mode,
    output reg o_pin_one_ground,
    output reg o_sysclk_sel_ext,
    output reg o_missing_clock_reset,
    output wire o_sysclk
);
    reg [7:0] int_ctrl_q;
    reg [6:0] ext_ctrl_q;
    reg [2:0] pin_sync_q;
    reg ready_q;
    reg [7:0] settle_q;
    reg [1:0] last_freq_q;
    reg valid_q;
    reg [2:0] ext_sync_q;
    reg [7:0] stable_q;
    reg ext_tog_q;
    reg [2:0] tog_sync_q;
    reg [7:0] loss_q;
    reg ext_div_q;
    reg ext_div_rst_q;
    reg [2:0] lock_sync_q;

    localparam [7:0] EXT_RESET = `EXT_OSC_CTRL_RESET;

    wire [2:0] mode = ext_ctrl_q[`EXT_MODE_HI:`EXT_MODE_LO];
    wire pin_low = ~pin_sync_q[2] & ~pin_sync_q[1];
    // lock counts only once both late stages agree high
    wire locked = lock_sync_q[2] & lock_sync_q[1];
    wire xtal_on = (mode == `MODE_XTAL) | (mode == `MODE_XTAL_DIV2);
    wire ext_on = mode[2] | mode[1];
    wire divide_on = (mode == `MODE_CMOS_DIV2) | (mode == 3'h4) |
        (mode == 3'h5) | (mode == `MODE_XTAL_DIV2);
    wire ext_raw = (mode[2:1] == 2'b01) ? i_pin_one_level : i_ext_osc_clk;
    wire ext_path;

    function [7:0] read_reg;
        input [7:0] addr;
        begin
            if (addr == `INT_OSC_CTRL_ADDR)
                read_reg = {int_ctrl_q[7], 2'b00, ready_q, int_ctrl_q[3:0]};
            else if (addr == `EXT_OSC_CTRL_ADDR)
                read_reg = {valid_q, ext_ctrl_q[6:4], 1'b0,
                    ext_ctrl_q[2:0]};
            else
                read_reg = 8'h00;
        end
    endfunction

    always @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn)
            pin_sync_q <= 3'h7;
        else
            pin_sync_q <= {pin_sync_q[1:0], i_reset_pin_n};
    end

    // analog lock level is asynchronous to i_clk
    always @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn)
            lock_sync_q <= 3'h0;
        else
            lock_sync_q <= {lock_sync_q[1:0], i_int_osc_locked};
    end

    always @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            int_ctrl_q <= `INT_OSC_CTRL_RESET;
            ext_ctrl_q <= EXT_RESET[6:0];
        end else if (i_reg_wr) begin
            if (i_reg_addr == `INT_OSC_CTRL_ADDR)
                int_ctrl_q <= {i_reg_wdata[7], 3'h0, i_reg_wdata[3:0]};
            else if (i_reg_addr == `EXT_OSC_CTRL_ADDR)
                ext_ctrl_q <= {i_reg_wdata[6:4], 1'b0,
                    i_reg_wdata[2:0]};
        end
    end

    // ready after the oscillator settles at the programmed code
    always @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            ready_q <= 1'b0;
            settle_q <= 8'h00;
            last_freq_q <= 2'b00;
        end else begin
            last_freq_q <= int_ctrl_q[1:0];
            if (!o_int_osc_enable || !locked ||
                last_freq_q != int_ctrl_q[1:0]) begin
                ready_q <= 1'b0;
                settle_q <= 8'h00;
            end else if (settle_q == `INT_SETTLE_CYCLES) begin
                ready_q <= 1'b1;
            end else begin
                settle_q <= settle_q + 8'h01;
            end
        end
    end

    // external clock seen as a toggle to count stable edges
    always @(posedge i_ext_osc_clk or negedge i_rstn) begin
        if (!i_rstn)
            ext_tog_q <= 1'b0;
        else
            ext_tog_q <= ~ext_tog_q;
    end

    always @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            tog_sync_q <= 3'h0;
            stable_q <= 8'h00;
            valid_q <= 1'b0;
            loss_q <= 8'h00;
            o_missing_clock_reset <= 1'b0;
        end else begin
            tog_sync_q <= {tog_sync_q[1:0], ext_tog_q};
            if (!xtal_on) begin
                stable_q <= 8'h00;
                valid_q <= 1'b0;
            end else if (tog_sync_q[2] != tog_sync_q[1]) begin
                if (stable_q == `XTAL_STABLE_EDGES)
                    valid_q <= 1'b1;
                else
                    stable_q <= stable_q + 8'h01;
            end
            // missing-clock watch of the external clock, only while it is selected
            if (!int_ctrl_q[`INT_LOSS_DET_BIT]) begin
                loss_q <= 8'h00;
                o_missing_clock_reset <= 1'b0;
            end else if (!o_sysclk_sel_ext ||
                tog_sync_q[2] != tog_sync_q[1]) begin
                loss_q <= 8'h00;
            end else if (loss_q == `LOSS_TIMEOUT_CYCLES) begin
                o_missing_clock_reset <= 1'b1;
            end else begin
                loss_q <= loss_q + 8'h01;
            end
        end
    end

    always @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_reg_rdata <= 8'h00;
            o_int_osc_enable <= 1'b0;
            o_int_freq_sel <= 2'b00;
            o_ext_osc_enable <= 1'b0;
            o_ext_freq_sel <= 3'h0;
            o_rc_mode <= 1'b0;
            o_xtal_mode <= 1'b0;
            o_pin_one_ground <= 1'b1;
            o_sysclk_sel_ext <= 1'b0;
        end else begin
            o_reg_rdata <= read_reg(i_reg_rd_addr);
            o_int_osc_enable <= int_ctrl_q[`INT_OSC_EN_BIT] & ~pin_low;
            o_int_freq_sel <= int_ctrl_q[1:0];
            o_ext_osc_enable <= ext_on & ~pin_low;
            o_ext_freq_sel <= ext_ctrl_q[2:0];
            o_rc_mode <= (mode[2:1] == 2'b10) & ~pin_low;
            o_xtal_mode <= xtal_on & ~pin_low;
            o_pin_one_ground <= ~ext_on | pin_low;
            o_sysclk_sel_ext <= int_ctrl_q[`INT_SRC_SEL_BIT];
        end
    end

    // divide-by-two stage on the external path
    always @(posedge ext_raw or negedge i_rstn) begin
        if (!i_rstn)
            ext_div_rst_q <= 1'b0;
        else
            ext_div_rst_q <= 1'b1;
    end

    always @(posedge ext_raw or negedge i_rstn) begin
        if (!i_rstn)
            ext_div_q <= 1'b0;
        else
            ext_div_q <= ~ext_div_q & ext_div_rst_q;
    end

    assign ext_path = divide_on ? ext_div_q : (ext_raw & ext_on);

    clock_glitch_free_mux u_clock_mux (
        .i_clk_a(i_int_osc_clk),
        .i_clk_b(ext_path),
        .i_rstn(i_rstn),
        .i_sel_b(o_sysclk_sel_ext),
        .o_clk(o_sysclk)
    );
endmodule // system_clock_source_control

// file: tb/osc_model.sv
/* oscillators and clock pin seen by the control block
   assumes enables and pin ground come from the control block */
`timescale 1ns/1ps
module osc_model (
    input wire i_int_en,
    input wire i_ext_en,
    input wire i_ground,
    input wire i_halt,
    output reg o_int_clk,
    output reg o_locked,
    output reg o_ext_clk,
    output wire o_pin
);
    initial o_int_clk = 1'b0;
    initial o_ext_clk = 1'b0;
    initial o_locked = 1'b0;
    // clocks stand still while disabled
    always #7 o_int_clk = i_int_en & ~o_int_clk;
    // halt stands for a lost external clock
    always #10 o_ext_clk = i_ext_en & ~i_halt & ~o_ext_clk;
    always @(i_int_en) o_locked <= #50 i_int_en;
    assign o_pin = ~i_ground & o_ext_clk;
endmodule // osc_model

// file: tb/clock_source_control_sva.sv
/* port checker of the clock source control
   assumes bind onto system_clock_source_control */
`timescale 1ns/1ps
`include "clock_source_control_defs.vh"
module clock_source_control_sva (
    input wire i_clk,
    input wire i_rstn,
    input wire i_reset_pin_n,
    input wire [7:0] i_reg_addr,
    input wire [7:0] i_reg_wdata,
    input wire i_reg_wr,
    input wire [7:0] i_reg_rd_addr,
    input wire [7:0] o_reg_rdata,
    input wire o_int_osc_enable,
    input wire [1:0] o_int_freq_sel,
    input wire o_ext_osc_enable,
    input wire o_xtal_mode,
    input wire o_pin_one_ground,
    input wire o_sysclk_sel_ext
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_rstn);
    wire wi = i_reg_wr && i_reg_addr == `INT_OSC_CTRL_ADDR;
    wire wx = i_reg_wr && i_reg_addr == `EXT_OSC_CTRL_ADDR;
    a_boot_internal: assert property (
        $rose(i_rstn) |-> !o_sysclk_sel_ext) else $error("not internal");
    a_pin_stops_osc: assert property (
        !i_reset_pin_n [*5] |=> !o_int_osc_enable && !o_ext_osc_enable)
        else $error("osc on in pin reset");
    a_select_follow: assert property (
        wi ##1 !i_reg_wr |-> ##1 o_sysclk_sel_ext == $past(i_reg_wdata[3], 2))
        else $error("select wrong");
    a_freq_follow: assert property (
        wi ##1 !i_reg_wr |-> ##1 o_int_freq_sel == $past(i_reg_wdata[1:0], 2))
        else $error("freq wrong");
    a_off_grounds: assert property (
        wx && i_reg_wdata[6:5] == 2'b00 ##1 !i_reg_wr
        |-> ##1 o_pin_one_ground && !o_ext_osc_enable) else $error("no ground");
    a_xtal_decode: assert property (
        wx ##1 !i_reg_wr
        |-> ##1 o_xtal_mode == ($past(i_reg_wdata[6:5], 2) == 2'b11))
        else $error("xtal wrong");
    a_unused_zero: assert property (
        i_reg_rd_addr == `INT_OSC_CTRL_ADDR |=> o_reg_rdata[6:5] == 2'b00)
        else $error("unused bits set");
    a_rsvd_zero: assert property (
        i_reg_rd_addr == `EXT_OSC_CTRL_ADDR |=> !o_reg_rdata[3])
        else $error("reserved set");
endmodule // clock_source_control_sva
bind system_clock_source_control clock_source_control_sva i_sva (.*);

// file: tb/tb_system_clock_source_control.sv
/* self-checking bench of the clock source control
   assumes the oscillator model on the analog side */
`timescale 1ns/1ps
`include "clock_source_control_defs.vh"
`define CHK(n, e, s) begin n_checks++; if ((s) !== (e)) begin \
    fail_count++; $display("BAD %s exp %h got %h", n, e, s); end end
module tb_system_clock_source_control;
    reg i_clk = 1'b0;
    reg i_rstn = 1'b1;
    reg halt = 1'b0;
    reg rpin_n = 1'b1;
    reg [7:0] wa = 8'h00;
    reg [7:0] wd = 8'h00;
    reg wr = 1'b0;
    reg [7:0] ra = 8'h00;
    wire [7:0] rdata;
    wire ien, lck, iclk, xen, xclk, pin, gnd, sel, xtal, rc, mcr;
    wire [1:0] fsel;
    wire [2:0] xfs;
    wire sysclk;
    integer sc_edges = 0;
    integer fail_count = 0;
    integer n_checks = 0;
    integer m;
    always #2.5 i_clk = ~i_clk;
    always @(posedge sysclk) sc_edges++;
    osc_model i_osc (.i_int_en(ien), .i_ext_en(xen), .i_ground(gnd),
        .i_halt(halt), .o_int_clk(iclk), .o_locked(lck), .o_ext_clk(xclk),
        .o_pin(pin));
    system_clock_source_control i_dut (.i_clk(i_clk), .i_rstn(i_rstn),
        .i_reset_pin_n(rpin_n), .i_reg_addr(wa), .i_reg_wdata(wd),
        .i_reg_wr(wr), .i_reg_rd_addr(ra), .i_int_osc_clk(iclk),
        .i_int_osc_locked(lck), .i_ext_osc_clk(xclk),
        .i_pin_one_level(pin), .o_reg_rdata(rdata), .o_int_osc_enable(ien),
        .o_int_freq_sel(fsel), .o_ext_osc_enable(xen), .o_ext_freq_sel(xfs),
        .o_rc_mode(rc), .o_xtal_mode(xtal), .o_pin_one_ground(gnd),
        .o_sysclk_sel_ext(sel), .o_missing_clock_reset(mcr),
        .o_sysclk(sysclk));
    task wr_reg(input [7:0] a, input [7:0] d);
        begin
            wa = a;
            wd = d;
            wr = 1'b1;
            @(posedge i_clk);
            #1 wr = 1'b0;
        end
    endtask
    task rd_reg(input [7:0] a, input [7:0] e);
        begin
            ra = a;
            repeat (2) @(posedge i_clk);
            #1 `CHK("rdata", e, rdata)
        end
    endtask
    task tally_and_finish;
        begin
            $display("checks %0d mismatches %0d", n_checks, fail_count);
            if (fail_count == 0 && n_checks > 0)
                $display("Simulation passed");
            else
                $display("Simulation failed");
            $finish;
        end
    endtask
    initial begin
        #100000;
        fail_count++;
        tally_and_finish;
    end
    initial begin
        #1 i_rstn = 1'b0;
        repeat (2) @(posedge i_clk);
        #1 i_rstn = 1'b1;
        rd_reg(`INT_OSC_CTRL_ADDR, 8'h04);
        rd_reg(`EXT_OSC_CTRL_ADDR, 8'h30);
        $display("reset test done");
        halt = 1'b1;
        wr_reg(`INT_OSC_CTRL_ADDR, 8'hFF);
        rd_reg(`INT_OSC_CTRL_ADDR, 8'h8F);
        repeat (120) @(posedge i_clk);
        #1 `CHK("loss", 1'b1, mcr)
        rd_reg(`INT_OSC_CTRL_ADDR, 8'h9F);
        `CHK("fsel", 2'h3, fsel)
        `CHK("sel", 1'b1, sel)
        wr_reg(`INT_OSC_CTRL_ADDR, 8'h04);
        rd_reg(`INT_OSC_CTRL_ADDR, 8'h04);
        `CHK("loss", 1'b0, mcr)
        `CHK("ien", 1'b1, ien)
        halt = 1'b0;
        $display("internal test done");
        for (m = 0; m < 8; m++) begin
            wr_reg(`EXT_OSC_CTRL_ADDR, {1'b1, m[2:0], 4'hF});
            rd_reg(`EXT_OSC_CTRL_ADDR, {1'b0, m[2:0], 4'h7});
            `CHK("gnd", m < 2, gnd)
            `CHK("xen", m > 1, xen)
            `CHK("rc", m[2:1] == 2'b10, rc)
            `CHK("xtal", m > 5, xtal)
            `CHK("xfreq", 3'h7, xfs)
        end
        $display("mode test done");
        wr_reg(`EXT_OSC_CTRL_ADDR, 8'h67);
        repeat (1500) @(posedge i_clk);
        #1 rd_reg(`EXT_OSC_CTRL_ADDR, 8'hE7);
        wr_reg(`INT_OSC_CTRL_ADDR, 8'h0C);
        rd_reg(`INT_OSC_CTRL_ADDR, 8'h1C);
        `CHK("sel", 1'b1, sel)
        m = sc_edges;
        repeat (20) @(posedge i_clk);
        #1 `CHK("sysclk", 1'b1, sc_edges > m)
        rpin_n = 1'b0;
        repeat (8) @(posedge i_clk);
        #1 `CHK("ien", 1'b0, ien)
        `CHK("xen", 1'b0, xen)
        rpin_n = 1'b1;
        i_rstn = 1'b0;
        @(posedge i_clk);
        #1 i_rstn = 1'b1;
        `CHK("sel", 1'b0, sel)
        rd_reg(`INT_OSC_CTRL_ADDR, 8'h04);
        $display("crystal test done");
        tally_and_finish;
    end
endmodule // tb_system_clock_source_control
